// ### pkg/trip_motion_pkg.sv
// Constants for the trip sequencer and steady-speed motion block
package trip_motion_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_OPA = 8'h08;
  localparam logic [7:0] REG_OPB = 8'h0C;
  localparam logic [7:0] REG_POS = 8'h10;
  localparam logic [7:0] REG_TRIP = 8'h14;
  localparam logic [7:0] REG_PINS = 8'h18;
  localparam logic [7:0] REG_INITV = 8'h1C;
  localparam logic [7:0] REG_SLOPE = 8'h20;
  localparam logic [7:0] REG_SHADDR = 8'h24;
  localparam logic [7:0] REG_SHDATA = 8'h28;
  localparam logic [7:0] REG_WAIT = 8'h2C;
  // Command codes written to REG_CMD
  localparam logic [3:0] CMD_TRIP_SET = 4'h1;
  localparam logic [3:0] CMD_REARM = 4'h2;
  localparam logic [3:0] CMD_PORT_WAIT = 4'h3;
  localparam logic [3:0] CMD_RUN = 4'h4;
  localparam logic [3:0] CMD_SOFT_STOP = 4'h5;
  localparam logic [3:0] CMD_ABORT = 4'h6;
  localparam logic [3:0] CMD_SAVE = 4'h7;
  // Shadow word opcodes, field [31:30]
  localparam logic [1:0] OP_TRIP = 2'h1;
  localparam logic [1:0] OP_REARM = 2'h2;
  // Shadow window 128..191 and the special counter start
  localparam int SHADOW_BASE = 128;
  localparam int SHADOW_WORDS = 64;
  // Jump address that selects the tight wait loop
  localparam logic [11:0] TIGHT_ADDR = 12'h800;
  // Reset values
  localparam logic [15:0] INITV_RST = 16'h0190;
  localparam logic [15:0] SLOPE_RST = 16'h0000;
  localparam logic [5:0] PORT_OFF = 6'h3F;
  localparam logic [5:0] OE_RST = 6'h3F;
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int POLL_US = 2000;
  localparam int POLL_CYC = POLL_US * (CLK_HZ / 1_000_000);
  localparam int RAMP_DELTA = 100;
endpackage : trip_motion_pkg

// ### verilog/trip_motion.sv
// Trip sequencer, loop-on-port wait and steady-speed motion engine
`timescale 1ns/1ps
// Behaviour
// - trip set loads ports, trip position, counter 128
// - match fetches shadow word, checks trip opcodes
// - trip actions land on the exact step
// - trip counter advances after each fetched trip word
// - port off drives high, applied at match
// - rearm also restarts counter, clears position
// - position clear never changes travel
// - shadow saved to nonvolatile, reloaded at reset
// - port wait jumps when level not met
// - condition code picks port and level
// - normal wait tests once after 2 ms
// - address 2048 waits tightly until met
// - port wait only while stored program runs
// - ports read from pins, outputs included
// - run ramps to signed target, holds it
// - sign change decelerates then reverses
// - zero/soft stop ramp down, abort stops
// - first run starts at initial velocity
// - slopes read fresh for each ramp
// - signed 24-bit position steps per step
// - trip compared on every step
module trip_motion
  import trip_motion_pkg::*;
#(
  parameter int POLL_CYCLES = POLL_CYC,
  parameter int STEP_CLK_HZ = CLK_HZ,
  parameter int PORTS = 6
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [PORTS-1:0] port_in,
  output logic [PORTS-1:0] port_out,
  output logic [PORTS-1:0] port_oe,
  output logic step,
  output logic dir
);
  typedef enum logic [1:0] {W_IDLE, W_POLL, W_TIGHT} wait_t;

  logic [31:0] shadow_q [SHADOW_WORDS];
  logic [31:0] nv_q [SHADOW_WORDS];
  logic [PORTS-1:0] pin_s1_q, pin_q, port_q, oe_q;
  logic [23:0] pos_q, trip_q, opa_q;
  logic [7:0] opb_q;
  logic [15:0] initv_q, slope_q, spd_q, tgt_q, spd_d;
  logic [5:0] tpc_q, shaddr_q;
  logic trip_on_q, run_q, dir_q, tdir_q, step_q, nvrun_q, refused_q;
  logic [26:0] acc_q;
  logic [26:0] acc_sum;
  logic [7:0] rcnt_q;
  logic [31:0] rdata_q;
  logic [23:0] pos_next;
  logic [31:0] tword;
  logic step_now, trip_hit, hit_trip, hit_rearm, hit_bad, met;
  logic [3:0] cmd;
  logic do_cmd;
  wait_t wst_q;
  logic [31:0] wcnt_q;
  logic jump_q, wdone_q;
  logic [11:0] jaddr_q;
  logic [15:0] vmag;
  logic [7:0] kval;
  logic want_up, want_down, at_floor;
  logic [15:0] want;

  // Condition code: port in bits 3:1, level in bit 0
  function automatic logic cond_ok(input logic [3:0] c, input logic [PORTS-1:0] p);
    if (c > 4'h9)
      cond_ok = 1'b0;
    else
      cond_ok = p[c[3:1]] == c[0];
  endfunction : cond_ok

  assign cmd = wdata[3:0];
  assign do_cmd = wr && addr == REG_CMD;
  assign vmag = opa_q[23] ? 16'(-opa_q) : opa_q[15:0];
  assign met = cond_ok(opb_q[3:0], pin_q);
  // Pins are two flops from any logic; outputs read back here too
  always_ff @(posedge clk)
  begin
    pin_s1_q <= port_in;
    pin_q <= pin_s1_q;
  end

  // Operand and setup registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      opa_q <= '0;
      opb_q <= '0;
      initv_q <= INITV_RST;
      slope_q <= SLOPE_RST;
      shaddr_q <= '0;
      nvrun_q <= 1'b0;
      oe_q <= OE_RST;
    end
    else if (wr)
    begin
      if (addr == REG_OPA)
        opa_q <= wdata[23:0];
      if (addr == REG_OPB)
        opb_q <= wdata[7:0];
      if (addr == REG_INITV)
        initv_q <= wdata[15:0];
      if (addr == REG_SLOPE)
        slope_q <= wdata[15:0];
      if (addr == REG_SHADDR)
        shaddr_q <= wdata[5:0];
      if (addr == REG_CTRL)
      begin
        nvrun_q <= wdata[0];
        oe_q <= wdata[PORTS:1];
      end
    end
  end

  // Shadow RAM; the nonvolatile copy is never reset so it survives
  always_ff @(posedge clk)
  begin
    if (reset)
      shadow_q <= nv_q;
    else if (wr && addr == REG_SHDATA)
      shadow_q[shaddr_q] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!reset && do_cmd && cmd == CMD_SAVE)
      nv_q <= shadow_q;
  end

  // Step timing: phase accumulator on speed in steps per second
  assign acc_sum = acc_q + 27'(spd_q);
  assign step_now = run_q && acc_sum >= 27'(STEP_CLK_HZ);
  assign pos_next = dir_q ? pos_q - 24'h1 : pos_q + 24'h1;
  // Ramp goal: zero while the sign disagrees, so reversal slows first
  assign want = (tdir_q == dir_q) ? tgt_q : 16'h0;
  assign want_up = spd_q < want;
  assign want_down = spd_q > want;
  assign at_floor = want == 16'h0 && spd_q <= initv_q;
  assign kval = want_up ? slope_q[7:0] : slope_q[15:8];

  // Next speed, one ramp point each time the dwell count expires
  always_comb
  begin
    spd_d = spd_q;
    if (kval == 8'h0 || rcnt_q + 8'h1 >= kval)
    begin
      if (want_up)
        spd_d = (want - spd_q > 16'(RAMP_DELTA) && kval != 8'h0) ?
          spd_q + 16'(RAMP_DELTA) : want;
      else if (want_down)
        spd_d = (spd_q - want > 16'(RAMP_DELTA) && kval != 8'h0) ?
          spd_q - 16'(RAMP_DELTA) : want;
      if (spd_d < initv_q && want_down)
        spd_d = initv_q;
    end
  end

  // Motion state; position changes never touch this, so travel holds
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      run_q <= 1'b0;
      spd_q <= '0;
      tgt_q <= '0;
      tdir_q <= 1'b0;
      dir_q <= 1'b0;
      acc_q <= '0;
      rcnt_q <= '0;
      step_q <= 1'b0;
    end
    else
    begin
      step_q <= step_now;
      if (do_cmd && cmd == CMD_ABORT)
      begin
        run_q <= 1'b0;
        spd_q <= '0;
        tgt_q <= '0;
        acc_q <= '0;
      end
      else if (do_cmd && cmd == CMD_RUN)
      begin
        tgt_q <= vmag;
        tdir_q <= opa_q[23];
        if (!run_q && vmag != 16'h0)
        begin
          run_q <= 1'b1;
          spd_q <= initv_q;
          dir_q <= opa_q[23];
          rcnt_q <= '0;
        end
      end
      else if (do_cmd && cmd == CMD_SOFT_STOP)
        tgt_q <= '0;
      else if (step_now)
      begin
        acc_q <= acc_sum - 27'(STEP_CLK_HZ);
        rcnt_q <= (kval == 8'h0 || rcnt_q + 8'h1 >= kval) ? 8'h0 : rcnt_q + 8'h1;
        if (at_floor && tgt_q == 16'h0)
          run_q <= 1'b0;
        else if (at_floor)
          dir_q <= tdir_q;
        else
          spd_q <= spd_d;
      end
      else if (run_q)
        acc_q <= acc_sum;
      else
        acc_q <= '0;
    end
  end

  // Trip match, checked on each step against the coming position
  assign tword = shadow_q[tpc_q];
  assign trip_hit = step_now && trip_on_q && pos_next == trip_q;
  assign hit_trip = trip_hit && tword[31:30] == OP_TRIP;
  assign hit_rearm = trip_hit && tword[31:30] == OP_REARM;
  assign hit_bad = trip_hit && !hit_trip && !hit_rearm;

  // Trip sequencer and ports; actions land on the matching edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      trip_on_q <= 1'b0;
      trip_q <= '0;
      tpc_q <= '0;
      port_q <= PORT_OFF;
    end
    else if (hit_trip || hit_rearm)
    begin
      port_q <= ~tword[24 +: PORTS];
      trip_q <= tword[23:0];
      tpc_q <= hit_rearm ? 6'h0 : tpc_q + 6'h1;
    end
    else if (hit_bad)
      trip_on_q <= 1'b0;
    else if (do_cmd && (cmd == CMD_TRIP_SET || cmd == CMD_REARM))
    begin
      port_q <= ~opb_q[PORTS-1:0];
      trip_q <= opa_q;
      tpc_q <= 6'h0;
      trip_on_q <= 1'b1;
    end
  end

  // Position counter: rearm clears it, origin writes load it
  always_ff @(posedge clk)
  begin
    if (reset)
      pos_q <= '0;
    else if (hit_rearm || (do_cmd && cmd == CMD_REARM))
      pos_q <= '0;
    else if (step_now)
      pos_q <= pos_next;
    else if (wr && addr == REG_POS)
      pos_q <= wdata[23:0];
  end

  // Loop-on-port engine
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wst_q <= W_IDLE;
      wcnt_q <= '0;
      jump_q <= 1'b0;
      wdone_q <= 1'b0;
      jaddr_q <= '0;
      refused_q <= 1'b0;
    end
    else
    begin
      // Set wins over a clear in the same cycle
      if (do_cmd && cmd == CMD_PORT_WAIT && !nvrun_q)
        refused_q <= 1'b1;
      else if (wr && addr == REG_CTRL && wdata[8])
        refused_q <= 1'b0;
      unique case (wst_q)
        W_IDLE:
          if (do_cmd && cmd == CMD_PORT_WAIT && nvrun_q)
          begin
            jaddr_q <= opa_q[11:0];
            wdone_q <= 1'b0;
            wcnt_q <= 32'(POLL_CYCLES - 1);
            wst_q <= opa_q[11:0] == TIGHT_ADDR ? W_TIGHT : W_POLL;
          end
        W_POLL:
          if (wcnt_q == 32'h0)
          begin
            jump_q <= !met;
            wdone_q <= 1'b1;
            wst_q <= W_IDLE;
          end
          else
            wcnt_q <= wcnt_q - 32'h1;
        W_TIGHT:
          if (met)
          begin
            jump_q <= 1'b0;
            wdone_q <= 1'b1;
            wst_q <= W_IDLE;
          end
      endcase
    end
  end

  // Read port: data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset || !rd)
      rdata_q <= '0;
    else
      unique case (addr)
        REG_CTRL: rdata_q <= {21'h0, refused_q, wst_q != W_IDLE, trip_on_q,
          tdir_q, dir_q, run_q, 4'h0, nvrun_q};
        REG_POS: rdata_q <= {{8{pos_q[23]}}, pos_q};
        REG_TRIP: rdata_q <= {2'h0, tpc_q, trip_q};
        REG_PINS: rdata_q <= 32'(pin_q);
        REG_INITV: rdata_q <= {16'h0, initv_q};
        REG_SLOPE: rdata_q <= {16'h0, slope_q};
        REG_SHDATA: rdata_q <= shadow_q[shaddr_q];
        REG_WAIT: rdata_q <= {18'h0, wdone_q, jump_q, jaddr_q};
        default: rdata_q <= '0;
      endcase
  end

  assign rdata = rdata_q;
  assign port_out = port_q;
  assign port_oe = oe_q;
  assign step = step_q;
  assign dir = dir_q;

  chk_trip_advance: assert property (@(posedge clk) disable iff (reset)
    hit_trip |=> tpc_q == $past(tpc_q) + 6'h1 && step_q)
    else $error("trip counter did not advance on step");
  chk_rearm_zero: assert property (@(posedge clk) disable iff (reset)
    hit_rearm |=> pos_q == 24'h0 && tpc_q == 6'h0)
    else $error("rearm did not clear position and counter");
  chk_trip_load: assert property (@(posedge clk) disable iff (reset)
    do_cmd && cmd == CMD_TRIP_SET && !trip_hit |=> trip_on_q && tpc_q == 6'h0
    && trip_q == $past(opa_q))
    else $error("trip set not loaded");
  chk_port_level: assert property (@(posedge clk) disable iff (reset)
    hit_trip |=> port_out == ~$past(tword[24 +: PORTS]))
    else $error("port level wrong after trip");
  chk_bad_stops: assert property (@(posedge clk) disable iff (reset)
    hit_bad |=> !trip_on_q ##1 !trip_on_q)
    else $error("bad opcode kept sequencing");
  chk_wait_refuse: assert property (@(posedge clk) disable iff (reset)
    do_cmd && cmd == CMD_PORT_WAIT && !nvrun_q && wst_q == W_IDLE
    |=> wst_q == W_IDLE && refused_q)
    else $error("port wait accepted outside program");
  chk_abort_stop: assert property (@(posedge clk) disable iff (reset)
    do_cmd && cmd == CMD_ABORT |=> !run_q && spd_q == 16'h0 ##1 !step_q)
    else $error("abort did not stop at once");
  chk_first_speed: assert property (@(posedge clk) disable iff (reset)
    do_cmd && cmd == CMD_RUN && !run_q && vmag != 16'h0 |=> run_q
    && spd_q == $past(initv_q))
    else $error("first run not at initial velocity");
  chk_pos_step: assert property (@(posedge clk) disable iff (reset)
    step_now && !hit_rearm |=> pos_q == $past(pos_next))
    else $error("position did not follow step");
  chk_tight_exit: assert property (@(posedge clk) disable iff (reset)
    wst_q == W_TIGHT && met |=> wst_q == W_IDLE && !jump_q && wdone_q)
    else $error("tight wait did not exit");
  cov_rearm: cover property (@(posedge clk) disable iff (reset) hit_rearm);
  cov_reverse: cover property (@(posedge clk) disable iff (reset)
    step_now && at_floor && tgt_q != 16'h0);
  cov_poll_jump: cover property (@(posedge clk) disable iff (reset)
    wst_q == W_POLL && wcnt_q == 32'h0 && !met);
endmodule : trip_motion

// ### testbench/motor_port_model.sv
// Behavioural stepper driver and port pin hardware for the trip block
`timescale 1ns/1ps
module motor_port_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic step,
  input wire logic dir,
  input wire logic [5:0] port_out,
  input wire logic [5:0] port_oe,
  input wire logic [5:0] ext_pins,
  output logic [5:0] pins,
  output int motor_pos
);
  // Pin level: the device wins where it drives, the outside world elsewhere
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      pins[i] = port_oe[i] ? port_out[i] : ext_pins[i];
    end
  end
  // Shaft travel, kept apart from the device counter so origin resets cannot hide lost steps
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      motor_pos <= 0;
    end
    else if (step === 1'b1)
    begin
      motor_pos <= dir ? motor_pos - 1 : motor_pos + 1;
    end
  end
endmodule : motor_port_model

// ### testbench/trip_motion_tb.sv
// Self-checking bench for trip sequencing, port wait and steady-speed motion
`timescale 1ns/1ps
module trip_motion_tb;
  import trip_motion_pkg::*;
  localparam int POLL = 8;
  // Step base scaled down so hundreds of steps fit the cycle budget
  localparam int STEP_HZ = 655_350;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [5:0] pins;
  logic [5:0] port_out;
  logic [5:0] port_oe;
  logic [5:0] ext_pins = 6'h00;
  logic step;
  logic dir;
  int motor_pos;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] v;
  int m;

  trip_motion #(.POLL_CYCLES(POLL), .PORTS(6), .STEP_CLK_HZ(STEP_HZ)) trip_motion_i (
    .clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_in(pins),
    .port_out(port_out), .port_oe(port_oe), .step(step), .dir(dir));
  motor_port_model motor_port_model_i (.clk(clk), .reset(reset), .step(step), .dir(dir),
    .port_out(port_out), .port_oe(port_oe), .ext_pins(ext_pins), .pins(pins),
    .motor_pos(motor_pos));

  // Bus cycles, launched just after a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : check
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    check(d, exp);
  endtask : chk_reg
  // Operands first, command last
  task automatic cmd(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b);
    wr_reg(REG_OPA, a);
    wr_reg(REG_OPB, b);
    wr_reg(REG_CMD, {28'h0, c});
  endtask : cmd
  // Bounded wait for the next trip action on the ports
  task automatic wait_port(input logic [5:0] exp);
    int n;
    n = 0;
    while (port_out !== exp && n < 20000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check({26'h0, port_out}, {26'h0, exp});
  endtask : wait_port

  task automatic test_reset;
    check({26'h0, port_out}, {26'h0, PORT_OFF});
    check({26'h0, port_oe}, {26'h0, OE_RST});
    check({30'h0, step, dir}, 32'h0000_0000);
    chk_reg(REG_INITV, {16'h0, INITV_RST});
    chk_reg(REG_SLOPE, {16'h0, SLOPE_RST});
    chk_reg(REG_POS, 32'h0000_0000);
    chk_reg(8'hF0, 32'h0000_0000);
    $display("test_reset done");
  endtask : test_reset

  // Three stored words: two trips, then a rearm that restarts the cycle
  task automatic test_trip;
    logic [31:0] prog [3];
    prog = '{{OP_TRIP, 6'h00, 24'd400}, {OP_TRIP, 6'h10, 24'd600}, {OP_REARM, 6'h08, 24'd200}};
    wr_reg(REG_INITV, 32'h0000_FFFF);
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(REG_SHADDR, i);
      wr_reg(REG_SHDATA, prog[i]);
    end
    chk_reg(REG_SHDATA, prog[2]);
    cmd(CMD_TRIP_SET, 32'h0000_00C8, 32'h0000_0008);
    check({26'h0, port_out}, 32'h0000_0037);
    chk_reg(REG_TRIP, 32'h0000_00C8);
    chk_reg(REG_PINS, 32'h0000_0037);
    cmd(CMD_RUN, 32'h0000_61A8, 32'h0000_0000);
    wait_port(6'h3F);
    chk_reg(REG_POS, 32'h0000_00C8);
    chk_reg(REG_TRIP, 32'h0100_0190);
    wait_port(6'h2F);
    chk_reg(REG_POS, 32'h0000_0190);
    chk_reg(REG_TRIP, 32'h0200_0258);
    wait_port(6'h37);
    chk_reg(REG_POS, 32'h0000_0000);
    chk_reg(REG_TRIP, 32'h0000_00C8);
    check(motor_pos, 600);
    wait_port(6'h3F);
    chk_reg(REG_POS, 32'h0000_00C8);
    check(motor_pos, 800);
    check({31'h0, dir}, 32'h0);
    $display("test_trip done");
  endtask : test_trip

  // Sign change while running, then a ramped stop
  task automatic test_reverse;
    int n;
    cmd(CMD_RUN, 32'h00FF_9E58, 32'h0000_0000);
    rd_reg(REG_CTRL, v);
    check({31'h0, v[7]}, 32'h1);
    n = 0;
    while (dir !== 1'b1 && n < 30000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, dir}, 32'h1);
    m = motor_pos;
    repeat (4000) @(posedge clk);
    check({31'h0, motor_pos < m}, 32'h1);
    cmd(CMD_SOFT_STOP, 32'h0, 32'h0);
    n = 0;
    v = 32'hFFFF_FFFF;
    while (v[5] !== 1'b0 && n < 5000)
    begin
      rd_reg(REG_CTRL, v);
      n++;
    end
    check({31'h0, v[5]}, 32'h0);
    m = motor_pos;
    repeat (3000) @(posedge clk);
    check(motor_pos, m);
    $display("test_reverse done");
  endtask : test_reverse

  // Abort must stop at once, without a ramp
  task automatic test_abort;
    m = motor_pos;
    cmd(CMD_RUN, 32'h0000_61A8, 32'h0000_0000);
    repeat (3000) @(posedge clk);
    check({31'h0, motor_pos != m}, 32'h1);
    cmd(CMD_ABORT, 32'h0, 32'h0);
    repeat (3) @(posedge clk);
    m = motor_pos;
    repeat (200) @(posedge clk);
    check(motor_pos, m);
    chk_reg(REG_CTRL, 32'h0000_0100);
    $display("test_abort done");
  endtask : test_abort

  // Every condition code met and unmet, then the tight loop
  task automatic test_wait;
    logic lvl;
    logic [5:0] sel;
    cmd(CMD_PORT_WAIT, 32'h0000_0123, 32'h0000_0001);
    rd_reg(REG_CTRL, v);
    check({31'h0, v[10]}, 32'h1);
    wr_reg(REG_CTRL, 32'h0000_0101);
    check({26'h0, port_oe}, 32'h0000_0000);
    for (int c = 0; c < 10; c++)
    begin
      for (int met = 0; met < 2; met++)
      begin
        sel = 6'h01 << (c / 2);
        lvl = (met == 1) ? c[0] : ~c[0];
        @(posedge clk);
        ext_pins <= lvl ? sel : ~sel;
        repeat (4) @(posedge clk);
        cmd(CMD_PORT_WAIT, 32'h0000_0100 + c, c);
        rd_reg(REG_WAIT, v);
        check({31'h0, v[13]}, 32'h0);
        repeat (POLL + 4) @(posedge clk);
        rd_reg(REG_WAIT, v);
        check({18'h0, v[13:0]}, {18'h0, 1'b1, met == 0, 12'h100 + c[11:0]});
      end
    end
    @(posedge clk);
    ext_pins <= 6'h00;
    repeat (4) @(posedge clk);
    cmd(CMD_PORT_WAIT, {20'h0, TIGHT_ADDR}, 32'h0000_0001);
    repeat (3 * POLL) @(posedge clk);
    rd_reg(REG_WAIT, v);
    check({31'h0, v[13]}, 32'h0);
    @(posedge clk);
    ext_pins <= 6'h01;
    repeat (5) @(posedge clk);
    rd_reg(REG_WAIT, v);
    check({30'h0, v[13:12]}, 32'h2);
    $display("test_wait done");
  endtask : test_wait

  // Save, then a software rearm, a bad stored opcode and a reset while running
  task automatic test_save;
    cmd(CMD_SAVE, 32'h0, 32'h0);
    wr_reg(REG_SLOPE, 32'h0000_0203);
    chk_reg(REG_SLOPE, 32'h0000_0203);
    wr_reg(REG_SHADDR, 32'h0);
    wr_reg(REG_SHDATA, 32'h0000_0000);
    wr_reg(REG_POS, 32'h0000_1234);
    chk_reg(REG_POS, 32'h0000_1234);
    cmd(CMD_REARM, 32'h0000_0004, 32'h0000_0008);
    chk_reg(REG_POS, 32'h0000_0000);
    chk_reg(REG_TRIP, 32'h0000_0004);
    check({26'h0, port_out}, 32'h0000_0037);
    cmd(CMD_RUN, 32'h0000_61A8, 32'h0000_0000);
    repeat (100) @(posedge clk);
    chk_reg(REG_CTRL, 32'h0000_0021);
    check({26'h0, port_out}, 32'h0000_0037);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check({26'h0, port_out}, {26'h0, PORT_OFF});
    check({30'h0, step, dir}, 32'h0000_0000);
    chk_reg(REG_CTRL, 32'h0000_0000);
    chk_reg(REG_SHDATA, {OP_TRIP, 6'h00, 24'd400});
    chk_reg(REG_INITV, {16'h0, INITV_RST});
    $display("test_save done");
  endtask : test_save

  task automatic report_and_stop;
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // 125 MHz clock
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Hang guard, well above the roughly 20k cycles the tests need
  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    test_reset();
    test_trip();
    test_reverse();
    test_abort();
    test_wait();
    test_save();
    report_and_stop();
  end
endmodule : trip_motion_tb
